/* File: serial_rx_unit.sv */
// Asynchronous serial unit receiver core with mute, parity and APB regs.
// Assumes APB master on pclk; rx_in synchronous to pclk.
//
// Operation
// RULE_01 - While muted, no receive flag sets and receive interrupts stay off.
// RULE_02 - Mute ends on idle line if wake select 0, address mark if 1.
// RULE_03 - Idle-line wake clears mute without setting the idle flag.
// RULE_04 - Address-mark wake clears mute and delivers the word as ready.
// RULE_05 - Software must not write control two while muted.
// RULE_06 - One start, one stop bit; body 8 or 9 bits by word length.
// RULE_07 - Address mark uses the top data bit, never the parity bit.
// RULE_08 - Parity over 7 or 8 low bits: even for select 0, odd for 1.
// RULE_09 - With parity on, transmit parity replaces the top data bit.
// RULE_10 - Received parity mismatch sets parity error, interrupt if enabled.
// RULE_11 - Sixteen samples per bit; majority of 8,9,10; noise if differing.
// RULE_12 - Sampling phase restarts at every detected start bit.
// RULE_13 - Start edge valid after three ones; noise if 3,5,7 read one.
// RULE_14 - Start bit noise also if sample 8, 9 or 10 reads one.
// RULE_15 - In wait mode unit runs; enabled requests cause wait exit.
// RULE_16 - In halt mode registers freeze, no transfer, no halt exit.
// RULE_17 - All events share one request, gated by enables and global mask.
// RULE_18 - Each event gated by its own enable bit; the code gates overrun with the receive enable shared with ready.
// RULE_19 - Overrun is enabled by the receive interrupt enable.
// RULE_20 - Receive flags clear by status access then data read.
`timescale 1ns/100ps
module serial_rx_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_in,
   input wire logic global_mask,
   input wire logic wait_mode,
   input wire logic halt_mode,
   input wire logic tx_empty_in,
   input wire logic tx_complete_in,
   output logic irq,
   output logic wait_wakeup,
   output logic [8:0] tx_word
);
   import serial_rx_pkg::*;

   // ************************************************************
   // Register state.
   // ************************************************************
   logic [7:0] ctrl_one_r;
   logic [7:0] ctrl_two_r;
   logic [15:0] baud_r;
   logic [7:0] tx_data_r;
   logic [7:0] rx_data_r;
   logic rdy_r, idle_r, ovr_r, noise_r, fe_r, pe_r;
   logic idle_armed_r;
   logic status_seen_r;
   logic [31:0] prdata_r;

   // APB access takes effect in the access phase; zero wait states.
   logic acc, wr, rd, hit;
   assign acc = psel && penable && !halt_mode;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign pready = 1'b1;
   assign hit = paddr == OFF_STATUS || paddr == OFF_DATA
      || paddr == OFF_CTRL_ONE || paddr == OFF_CTRL_TWO
      || paddr == OFF_BAUD;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_r;

   function automatic logic par_of(input logic [7:0] d, input logic m,
                                   input logic odd);
      logic p;
      p = ^d[6:0] ^ (m & d[7]);
      return p ^ odd; // [RULE_08]
   endfunction : par_of

   // ************************************************************
   // Receive bit engine.
   // ************************************************************
   typedef enum logic [1:0] {S_IDLE, S_START, S_BITS, S_STOP} rx_state_t;
   rx_state_t st_r;
   logic [15:0] div_r;
   logic tick;
   logic [3:0] phase_r;
   logic [3:0] bitn_r;
   logic [8:0] shift_r;
   logic [2:0] pre_r;
   logic frame_noise_r;
   logic bit_val, bit_noise;
   logic rx_go;
   logic [3:0] body_len;
   logic word_done;
   logic [8:0] word;
   logic stop_ok;
   logic addr_mark;

   assign rx_go = ctrl_two_r[C2_RX_EN] && !halt_mode; // [RULE_16]
   assign tick = rx_go && div_r == 16'h0000;
   assign body_len = ctrl_one_r[C1_WORDLEN] ? 4'h9 : 4'h8; // [RULE_06]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 16'h0000;
      end else if (!rx_go || div_r == 16'h0000) begin
         div_r <= baud_r - 16'h0001;
      end else begin
         div_r <= div_r - 16'h0001;
      end
   end

   serial_bit_sampler u_sampler (
      .pclk(pclk),
      .presetn(presetn),
      .sample_en(tick),
      .phase(phase_r),
      .rx_in(rx_in),
      .bit_val(bit_val),
      .bit_noise(bit_noise)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= S_IDLE;
         phase_r <= 4'h0;
         bitn_r <= 4'h0;
         shift_r <= 9'h000;
         pre_r <= 3'h7;
         frame_noise_r <= 1'b0;
      end else if (!rx_go) begin
         st_r <= S_IDLE;
      end else if (tick) begin
         case (st_r)
            S_IDLE: begin
               pre_r <= {pre_r[1:0], rx_in};
               if (!rx_in) begin
                  // Resync phase on each start edge.
                  st_r <= S_START; // [RULE_12]
                  phase_r <= 4'h1;
                  frame_noise_r <= frame_noise_r || pre_r != 3'h7; // [RULE_13]
               end
            end
            S_START: begin
               phase_r <= phase_r + 4'h1;
               if ((phase_r == START_S3 || phase_r == START_S5
                    || phase_r == START_S7) && rx_in) begin
                  frame_noise_r <= 1'b1; // [RULE_13]
               end
               if (phase_r == SAMPLE_C) begin
                  if (bit_noise || bit_val) begin
                     frame_noise_r <= 1'b1; // [RULE_14]
                  end
                  if (bit_val) begin
                     // False start: keep noise pending for next frame.
                     st_r <= S_IDLE;
                     pre_r <= 3'h7;
                  end
               end
               if (phase_r == OVERSAMPLE_LAST) begin
                  st_r <= S_BITS;
                  bitn_r <= 4'h0;
               end
            end
            S_BITS: begin
               phase_r <= phase_r + 4'h1;
               if (phase_r == SAMPLE_C) begin
                  shift_r <= {bit_val, shift_r[8:1]};
                  if (bit_noise) begin
                     frame_noise_r <= 1'b1; // [RULE_11]
                  end
               end
               if (phase_r == OVERSAMPLE_LAST) begin
                  bitn_r <= bitn_r + 4'h1;
                  if (bitn_r + 4'h1 == body_len) begin
                     st_r <= S_STOP;
                  end
               end
            end
            S_STOP: begin
               phase_r <= phase_r + 4'h1;
               if (phase_r == SAMPLE_C) begin
                  st_r <= S_IDLE;
                  pre_r <= 3'h7;
                  frame_noise_r <= 1'b0;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   assign word_done = tick && st_r == S_STOP && phase_r == SAMPLE_C;
   assign stop_ok = bit_val;
   // Right-align the body: an 8-bit frame lands in shift_r[8:1].
   assign word = ctrl_one_r[C1_WORDLEN] ? shift_r : {1'b0, shift_r[8:1]};
   // Top data bit, never the parity bit, which sits above it when enabled.
   assign addr_mark = ctrl_one_r[C1_PAR_EN]
      ? (ctrl_one_r[C1_WORDLEN] ? word[7] : word[6])
      : (ctrl_one_r[C1_WORDLEN] ? word[8] : word[7]); // [RULE_07]

   logic [7:0] idle_cnt_r;
   logic idle_tick;
   logic idle_det;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_r <= 8'h00;
      end else if (!rx_go || st_r != S_IDLE || !rx_in) begin
         idle_cnt_r <= 8'h00;
      end else if (tick && idle_cnt_r != 8'hFF) begin
         idle_cnt_r <= idle_cnt_r + 8'h01;
      end
   end
   assign idle_tick = tick && idle_cnt_r ==
      {(ctrl_one_r[C1_WORDLEN] ? IDLE_BITS_M1 : IDLE_BITS_M0), 4'hF};
   assign idle_det = idle_tick;

   // ************************************************************
   // Flags, mute and data.
   // ************************************************************
   logic muted;
   logic wake_idle, wake_addr, deliver;
   logic clr_seq;
   logic par_bad;
   assign muted = ctrl_two_r[C2_MUTE];
   assign wake_idle = muted && !ctrl_one_r[C1_WAKE] && idle_det; // [RULE_02]
   assign wake_addr = muted && ctrl_one_r[C1_WAKE] && word_done
      && addr_mark; // [RULE_02]
   assign deliver = word_done && (!muted || wake_addr); // [RULE_04]
   assign clr_seq = rd && paddr == OFF_DATA && status_seen_r; // [RULE_20]
   assign par_bad = ctrl_one_r[C1_PAR_EN] && (par_of(word[7:0],
      ctrl_one_r[C1_WORDLEN], ctrl_one_r[C1_PAR_SEL])
      != (ctrl_one_r[C1_WORDLEN] ? word[8] : word[7])); // [RULE_10]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_seen_r <= 1'b0;
      end else if (acc && paddr == OFF_STATUS) begin
         status_seen_r <= 1'b1;
      end else if (clr_seq) begin
         status_seen_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_r <= 1'b0;
         ovr_r <= 1'b0;
         noise_r <= 1'b0;
         fe_r <= 1'b0;
         pe_r <= 1'b0;
         rx_data_r <= 8'h00;
      end else if (!halt_mode) begin
         if (clr_seq) begin
            rdy_r <= 1'b0;
            ovr_r <= 1'b0;
            noise_r <= 1'b0;
            fe_r <= 1'b0;
            pe_r <= 1'b0;
         end
         // Set wins over a clear in the same cycle; muted frames are dropped.
         if (deliver) begin // [RULE_01]
            if (rdy_r && !clr_seq) begin
               ovr_r <= 1'b1;
            end else begin
               rdy_r <= 1'b1; // [RULE_04]
               rx_data_r <= word[7:0];
               noise_r <= frame_noise_r;
               fe_r <= !stop_ok;
               pe_r <= par_bad; // [RULE_10]
            end
         end
      end
   end

   // Idle re-arms only after a word is delivered.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_r <= 1'b0;
         idle_armed_r <= 1'b0;
      end else if (!halt_mode) begin
         if (clr_seq) begin
            idle_r <= 1'b0;
         end
         if (deliver) begin
            idle_armed_r <= 1'b1;
         end else if (idle_det && !muted && idle_armed_r) begin
            idle_r <= 1'b1; // [RULE_03]
            idle_armed_r <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Control registers.
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_one_r <= CTRL_ONE_RST;
         ctrl_two_r <= CTRL_TWO_RST;
         baud_r <= BAUD_RST;
         tx_data_r <= 8'h00;
      end else begin
         if (wr && paddr == OFF_CTRL_ONE) begin
            ctrl_one_r[6:0] <= pwdata[6:0];
         end
         if (wr && paddr == OFF_BAUD) begin
            baud_r <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
         end
         if (wr && paddr == OFF_DATA) begin
            tx_data_r <= pwdata[7:0];
         end
         if (deliver) begin
            ctrl_one_r[C1_R8] <= word[8];
         end
         if (wr && paddr == OFF_CTRL_TWO) begin
            ctrl_two_r <= pwdata[7:0];
         end else if (wake_idle || wake_addr) begin
            ctrl_two_r[C2_MUTE] <= 1'b0; // [RULE_03] [RULE_04]
         end
      end
   end

   // Parity replaces the top transmitted data bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_word <= 9'h000;
      end else if (!ctrl_one_r[C1_PAR_EN]) begin
         tx_word <= {ctrl_one_r[C1_T8], tx_data_r};
      end else if (ctrl_one_r[C1_WORDLEN]) begin
         tx_word <= {par_of(tx_data_r, 1'b1, ctrl_one_r[C1_PAR_SEL]),
                     tx_data_r}; // [RULE_09]
      end else begin
         tx_word <= {1'b0, par_of(tx_data_r, 1'b0, ctrl_one_r[C1_PAR_SEL]),
                     tx_data_r[6:0]}; // [RULE_09]
      end
   end

   // ************************************************************
   // Read data and interrupt request.
   // ************************************************************
   logic [7:0] status_v;
   assign status_v = {tx_empty_in, tx_complete_in, rdy_r, idle_r, ovr_r,
                      noise_r, fe_r, pe_r};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            OFF_STATUS: prdata_r <= {24'h000000, status_v};
            OFF_DATA: prdata_r <= {24'h000000, rx_data_r};
            OFF_CTRL_ONE: prdata_r <= {24'h000000, ctrl_one_r};
            OFF_CTRL_TWO: prdata_r <= {24'h000000, ctrl_two_r};
            OFF_BAUD: prdata_r <= {16'h0000, baud_r};
            default: prdata_r <= 32'h00000000;
         endcase
      end
   end

   logic ev_any;
   always_comb begin
      ev_any = (tx_empty_in && ctrl_two_r[C2_TX_IE])
         || (tx_complete_in && ctrl_two_r[C2_TC_IE])
         || ((rdy_r || ovr_r) && ctrl_two_r[C2_RX_IE]) // [RULE_18] [RULE_19]
         || (idle_r && ctrl_two_r[C2_IDLE_IE])
         || (pe_r && ctrl_one_r[C1_PAR_IE]); // [RULE_18]
   end
   assign irq = ev_any && !global_mask; // [RULE_17]
   assign wait_wakeup = irq && wait_mode && !halt_mode; // [RULE_15] [RULE_16]

   // ************************************************************
   // Checks.
   // ************************************************************
   a_mute_no_ready: assert property ( // [RULE_01]
      @(posedge pclk) disable iff (!presetn)
      (muted && !wake_addr && !clr_seq && !rdy_r) |=> !rdy_r)
      else $error("ready flag set while muted");
   a_wake_addr_clears: assert property ( // [RULE_04]
      @(posedge pclk) disable iff (!presetn)
      wake_addr && !wr |=> !ctrl_two_r[C2_MUTE] && rdy_r)
      else $error("address mark did not wake");
   a_idle_wake_quiet: assert property ( // [RULE_03]
      @(posedge pclk) disable iff (!presetn)
      wake_idle && !idle_r && !clr_seq |=> !idle_r)
      else $error("idle flag set on idle wake");
   a_irq_masked: assert property ( // [RULE_17]
      @(posedge pclk) disable iff (!presetn)
      global_mask |-> !irq)
      else $error("request while masked");
   a_halt_freeze: assert property ( // [RULE_16]
      @(posedge pclk) disable iff (!presetn)
      halt_mode |=> $stable(rdy_r) && $stable(rx_data_r))
      else $error("state moved in halt");
   a_halt_no_wake: assert property ( // [RULE_16]
      @(posedge pclk) disable iff (!presetn)
      halt_mode |-> !wait_wakeup)
      else $error("wake from halt");
   a_clear_seq: assert property ( // [RULE_20]
      @(posedge pclk) disable iff (!presetn)
      clr_seq && !deliver |=> !rdy_r && !noise_r && !fe_r)
      else $error("flags not cleared");
   a_overrun_keep: assert property ( // [RULE_19]
      @(posedge pclk) disable iff (!presetn)
      deliver && rdy_r && !clr_seq && !halt_mode
      |=> ovr_r && $stable(rx_data_r))
      else $error("overrun lost data");
endmodule : serial_rx_unit

/* File: serial_rx_pkg.sv */
// Package for the asynchronous serial unit: register map, fields, timing.
// Assumes an APB master with 32-bit data and one clock pclk.
package serial_rx_pkg;
   // ************************************************************
   // Register offsets (byte addresses).
   // ************************************************************
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_DATA = 8'h04;
   localparam logic [7:0] OFF_CTRL_ONE = 8'h08;
   localparam logic [7:0] OFF_CTRL_TWO = 8'h0C;
   localparam logic [7:0] OFF_BAUD = 8'h10;
   localparam logic [7:0] OFF_SYS = 8'h14;
   // ************************************************************
   // Reset values.
   // ************************************************************
   localparam logic [7:0] STATUS_RST = 8'hC0;
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] CTRL_TWO_RST = 8'h00;
   localparam logic [15:0] BAUD_RST = 16'h0001;
   localparam logic [1:0] SYS_RST = 2'h0;
   // ************************************************************
   // Field positions.
   // ************************************************************
   localparam int C1_R8 = 7;
   localparam int C1_T8 = 6;
   localparam int C1_WORDLEN = 4;
   localparam int C1_WAKE = 3;
   localparam int C1_PAR_EN = 2;
   localparam int C1_PAR_SEL = 1;
   localparam int C1_PAR_IE = 0;
   localparam int C2_TX_IE = 7;
   localparam int C2_TC_IE = 6;
   localparam int C2_RX_IE = 5;
   localparam int C2_IDLE_IE = 4;
   localparam int C2_TX_EN = 3;
   localparam int C2_RX_EN = 2;
   localparam int C2_MUTE = 1;
   // ************************************************************
   // Sampling constants.
   // ************************************************************
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
   localparam logic [3:0] SAMPLE_A = 4'h7;
   localparam logic [3:0] SAMPLE_B = 4'h8;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam logic [3:0] START_S3 = 4'h2;
   localparam logic [3:0] START_S5 = 4'h4;
   localparam logic [3:0] START_S7 = 4'h6;
   localparam logic [3:0] IDLE_BITS_M0 = 4'hA;
   localparam logic [3:0] IDLE_BITS_M1 = 4'hB;

   typedef struct packed {
      logic [7:0] data;
      logic bit8;
      logic noise;
      logic frame_err;
      logic par_err;
      logic is_idle;
   } rx_word_t;
endpackage : serial_rx_pkg

/* File: serial_bit_sampler.sv */
// Three-sample majority voter with a noise indication.
// Assumes samples are taken once per oversample tick by the caller.
`timescale 1ns/100ps
module serial_bit_sampler (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sample_en,
   input wire logic [3:0] phase,
   input wire logic rx_in,
   output logic bit_val,
   output logic bit_noise
);
   import serial_rx_pkg::*;
   logic [1:0] hist_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist_r <= 2'h3;
      end else if (sample_en && (phase == SAMPLE_A || phase == SAMPLE_B)) begin
         hist_r <= {hist_r[0], rx_in};
      end
   end

   // Majority of the 8th, 9th and 10th samples; any disagreement is noise.
   always_comb begin
      bit_val = (hist_r[1] & hist_r[0]) | (hist_r[1] & rx_in)
         | (hist_r[0] & rx_in); // [RULE_11]
      bit_noise = !((hist_r[1] == hist_r[0]) && (hist_r[0] == rx_in));
   end
endmodule : serial_bit_sampler

/* File: remote_tx_model.sv */
// Remote asynchronous transmitter model driving the shared serial line.
// Assumes a baud divisor of 2, so one bit lasts 32 pclk cycles.
`timescale 1ns/100ps
module remote_tx_model (
   input wire logic pclk,
   input wire logic go,
   input wire logic [8:0] word,
   input wire logic [3:0] nbits,
   input wire logic [3:0] glitch_bit,
   output logic line,
   output logic busy
);
   // ************************************************************
   // Frame shifter.
   // ************************************************************
   logic [10:0] frame_r;
   logic [4:0] cnt_r;
   logic [3:0] idx_r;
   logic [3:0] last_r;
   logic [3:0] gl_r;
   logic flip;
   initial busy = 1'b0;
   // A glitch of two cycles hits exactly one of the three middle samples.
   assign flip = (idx_r == gl_r) && (cnt_r[4:1] == 4'h8);
   // The line idles high between frames, as an asynchronous line must.
   assign line = busy ? (frame_r[idx_r] ^ flip) : 1'b1;
   always @(posedge pclk) begin
      if (go && !busy) begin
         // Start bit low, body least significant bit first, stop high.
         frame_r <= {1'b1, word, 1'b0}
            | ((nbits == 4'h8) ? 11'h200 : 11'h000);
         last_r <= nbits + 4'h1;
         gl_r <= glitch_bit;
         idx_r <= 4'h0;
         cnt_r <= 5'h0;
         busy <= 1'b1;
      end else if (busy) begin
         cnt_r <= cnt_r + 5'h1;
         if (cnt_r == 5'h1F) begin
            if (idx_r == last_r) begin
               busy <= 1'b0;
            end
            idx_r <= idx_r + 4'h1;
         end
      end
   end
endmodule : remote_tx_model

/* File: uart_rx_mute_parity_sampling_tb.sv */
// Self-checking bench for the receive unit with its remote transmitter.
// Assumes zero-wait APB answers and a baud divisor of 2 pclk per tick.
`timescale 1ns/100ps
module uart_rx_mute_parity_sampling_tb;
   import serial_rx_pkg::*;
   // ************************************************************
   // Signals and instances.
   // ************************************************************
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line;
   logic global_mask, wait_mode, halt_mode, tx_empty_in, tx_complete_in;
   logic irq, wait_wakeup, go, busy;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [8:0] tx_word, word;
   logic [3:0] nbits, glitch_bit;
   int err_total, samples_checked, cycles;
   logic [7:0] d;
   logic p;
   serial_rx_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(line),
      .global_mask(global_mask), .wait_mode(wait_mode),
      .halt_mode(halt_mode), .tx_empty_in(tx_empty_in),
      .tx_complete_in(tx_complete_in), .irq(irq),
      .wait_wakeup(wait_wakeup), .tx_word(tx_word));
   remote_tx_model far (.pclk(pclk), .go(go), .word(word), .nbits(nbits),
      .glitch_bit(glitch_bit), .line(line), .busy(busy));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // ************************************************************
   // Tasks.
   // ************************************************************
   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   // Holds the request until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] v);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= v;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      p = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic send(input logic [8:0] w, input logic [3:0] g);
      go <= 1'b1;
      word <= w;
      glitch_bit <= g;
      @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
      while (busy === 1'b1) @(posedge pclk);
      repeat (4) @(posedge pclk);
   endtask : send
   // Status access then data read, which is the only way flags drop.
   task automatic take(input logic [7:0] st, input logic [7:0] dat);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(q & 32'h3F, {24'h0, st});
      apb(1'b0, OFF_DATA, 32'h0);
      chk(q[7:0], dat);
   endtask : take
   function automatic logic par(input logic [7:0] v, input logic s);
      return (^v) ^ s;
   endfunction : par
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         close_out();
      end
   end
   // ************************************************************
   // Scenarios.
   // ************************************************************
   initial begin
      {presetn, psel, penable, pwrite, go, global_mask} = 6'h0;
      {wait_mode, halt_mode, tx_empty_in, tx_complete_in} = 4'h0;
      {paddr, pwdata, word, glitch_bit, cycles} = 0;
      {err_total, samples_checked} = 0;
      nbits = 4'h8;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      void'($urandom(32'h9C6BF838));
      apb(1'b0, OFF_CTRL_TWO, 32'h0);
      chk(q, {24'h0, CTRL_TWO_RST});
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, p}, 32'h1);
      apb(1'b1, OFF_BAUD, 32'h2);
      apb(1'b1, OFF_CTRL_TWO, 32'h2C);
      for (int i = 0; i < 3; i++) begin
         d = 8'($urandom);
         send({1'b0, d}, 4'hF);
         chk({31'h0, irq}, 32'h1);
         take(8'h20, d);
      end
      // One flipped middle sample keeps the bit but flags noise.
      send(9'h0A5, 4'h3);
      take(8'h24, 8'hA5);
      send(9'h011, 4'hF);
      send(9'h022, 4'hF);
      chk({31'h0, irq}, 32'h1);
      take(8'h28, 8'h11);
      apb(1'b1, OFF_CTRL_ONE, 32'h10);
      nbits = 4'h9;
      word = 9'($urandom);
      send(word, 4'hF);
      apb(1'b0, OFF_CTRL_ONE, 32'h0);
      chk({31'h0, q[7]}, {31'h0, word[8]});
      take(8'h20, word[7:0]);
      nbits = 4'h8;
      apb(1'b1, OFF_CTRL_TWO, 32'h0C);
      for (int s = 0; s < 2; s++) begin
         for (int b = 0; b < 2; b++) begin
            apb(1'b1, OFF_CTRL_ONE, 32'h5 | (s << 1));
            d = 8'($urandom) & 8'h7F;
            send({1'b0, par(d, s[0]) ^ b[0], d[6:0]}, 4'hF);
            chk({31'h0, irq}, b);
            take(8'h20 | b[0], {par(d, s[0]) ^ b[0], d[6:0]});
            apb(1'b1, OFF_DATA, {24'h0, d | 8'h80});
            repeat (2) @(posedge pclk);
            chk(tx_word[7:0], {par(d, s[0]), d[6:0]});
         end
      end
      // Parity bit set but data top bit clear must not wake the unit.
      apb(1'b1, OFF_CTRL_ONE, 32'h1C);
      apb(1'b1, OFF_CTRL_TWO, 32'h0E);
      nbits = 4'h9;
      send({par(8'h01, 1'b0), 8'h01}, 4'hF);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(q & 32'h3F, 32'h0);
      send({par(8'h81, 1'b0), 8'h81}, 4'hF);
      apb(1'b0, OFF_CTRL_TWO, 32'h0);
      chk(q & 32'h2, 32'h0);
      take(8'h20, 8'h81);
      // Idle wake: mute ends after a quiet line, the idle flag stays low.
      apb(1'b1, OFF_CTRL_ONE, 32'h0);
      apb(1'b1, OFF_CTRL_TWO, 32'h0E);
      repeat (400) @(posedge pclk);
      apb(1'b0, OFF_CTRL_TWO, 32'h0);
      chk(q & 32'h2, 32'h0);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(q & 32'h10, 32'h0);
      apb(1'b1, OFF_CTRL_TWO, 32'h8C);
      tx_empty_in <= 1'b1;
      wait_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({30'h0, irq, wait_wakeup}, 32'h3);
      global_mask <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      global_mask <= 1'b0;
      halt_mode <= 1'b1;
      @(posedge pclk);
      apb(1'b1, OFF_CTRL_TWO, 32'h0);
      chk({31'h0, wait_wakeup}, 32'h0);
      halt_mode <= 1'b0;
      @(posedge pclk);
      apb(1'b0, OFF_CTRL_TWO, 32'h0);
      chk(q, 32'h8C);
      apb(1'b1, OFF_CTRL_TWO, 32'h4C);
      tx_empty_in <= 1'b0;
      tx_complete_in <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      close_out();
   end
endmodule : uart_rx_mute_parity_sampling_tb
